// [logic/tpc_pkg.sv]
// Package: shared constants and carrier types for the trace and pass counter block
package tpc_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int TS_W = 32;
    localparam int REG_W = 16;
    localparam int PASS_W = 16;
    localparam int DEPTH = 8192;
    localparam int NUM_BRK = 4;
    localparam int IDX_W = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PASS_W-1:0] PASS_RST = 16'h0000;
    localparam logic [TS_W-1:0] TS_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
    } tpc_range_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [TS_W-1:0] stamp;
        logic [REG_W-1:0] changed;
    } tpc_rec_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [REG_W-1:0] changed;
    } tpc_cyc_t;

    typedef enum logic [2:0] {
        PC_IDLE = 3'b001,
        PC_COUNT = 3'b010,
        PC_DONE = 3'b100
    } tpc_pc_state_t;

endpackage

// [logic/tpc_trace_mem.sv]
// Circular trace record memory with write pointer and readout port
`timescale 1ns/1ps
module tpc_trace_mem #(
    parameter int DEPTH = tpc_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire tpc_pkg::tpc_rec_t wr_rec,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output tpc_pkg::tpc_rec_t rd_rec,
    output logic [$clog2(DEPTH)-1:0] wr_ptr,
    output logic full
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("tpc_trace_mem: DEPTH must be a power of two, at least 2");
    end

    tpc_pkg::tpc_rec_t mem [DEPTH];
    logic [AW-1:0] ptr_q;
    logic full_q;

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[ptr_q] <= wr_rec;
        rd_rec <= mem[rd_idx];
    end

    // Pointer wraps, so the oldest record is overwritten once full
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ptr_q <= '0;
            full_q <= 1'b0;
        end
        else if (wr_en)
        begin
            ptr_q <= ptr_q + 1'b1;
            if (ptr_q == AW'(DEPTH - 1))
                full_q <= 1'b1;
        end
    end

    assign wr_ptr = ptr_q;
    assign full = full_q;
endmodule

// [logic/tpc_trace_pass.sv]
// Trace capture, stopwatch time stamp, pass counter and break logic
// Notes on behaviour
// - Record holds address, data, stamp, changed registers
// - Active trace writes every selected cycle
// - Trace halt freezes buffer; core keeps running
// - Stamp is stopwatch counter; clearing resets it
// - 16-bit pass counter decrements on range match
// - Break-assigned counter at zero halts core
// - Halt on first of break hit or zero
// - Break and pass ranges evaluated independently
// - Trace-assigned counter blocks writes until zero
// - After zero, trace writes every valid cycle
// - Counter decrements once per selected event
// - 8K circular buffer; optional halt when full
// - Address break halts before matching instruction
`timescale 1ns/1ps
module tpc_trace_pass #(
    parameter int NUM_BRK = tpc_pkg::NUM_BRK,
    parameter int DEPTH = tpc_pkg::DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire tpc_pkg::tpc_cyc_t CYC,
    input wire logic [tpc_pkg::ADDR_W-1:0] FETCH_ADDR,
    input wire logic FETCH_VALID,
    input wire logic CORE_HALTED,
    input wire logic EVENT_IN,
    input wire logic EXT_BREAK,
    input wire tpc_pkg::tpc_range_t [NUM_BRK-1:0] BRK_RANGE,
    input wire logic [NUM_BRK-1:0] BRK_EN,
    input wire tpc_pkg::tpc_range_t PASS_RANGE,
    input wire logic PASS_EN,
    input wire logic PASS_USE_EVENT,
    input wire logic PASS_TO_TRACE,
    input wire logic PASS_LOAD,
    input wire logic [tpc_pkg::PASS_W-1:0] PASS_LOAD_VAL,
    input wire logic TRACE_EN,
    input wire logic BREAK_ON_FULL,
    input wire logic TRACE_HALT_REQ,
    input wire logic SW_CLEAR,
    input wire logic [tpc_pkg::IDX_W-1:0] RD_IDX,
    output tpc_pkg::tpc_rec_t RD_REC,
    output logic [tpc_pkg::IDX_W-1:0] WR_PTR,
    output logic BUF_FULL,
    output logic TRACE_FROZEN,
    output logic [tpc_pkg::PASS_W-1:0] PASS_COUNT,
    output logic PASS_ZERO,
    output logic [tpc_pkg::TS_W-1:0] STOPWATCH,
    output logic HALT_REQ
);
    localparam int AW = tpc_pkg::IDX_W;

    if (NUM_BRK < 1)
    begin : g_bad_brk
        $error("tpc_trace_pass: NUM_BRK must be at least 1");
    end
    if (DEPTH != tpc_pkg::DEPTH)
    begin : g_bad_depth
        $error("tpc_trace_pass: DEPTH must match the package record index width");
    end

    // ------------------------------------------------------------
    // Range decode
    // ------------------------------------------------------------
    function automatic logic in_range(input tpc_pkg::tpc_range_t r,
                                      input logic [tpc_pkg::ADDR_W-1:0] a);
        in_range = (a >= r.start_addr) && (a <= r.end_addr);
    endfunction

    // Break ranges watch the fetch address so the halt lands before execution
    logic [NUM_BRK-1:0] brk_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BRK; gi++)
        begin : g_brk
            assign brk_hit[gi] = BRK_EN[gi] && FETCH_VALID
                && in_range(BRK_RANGE[gi], FETCH_ADDR);
        end
    endgenerate

    // Pass range uses its own comparator, unaffected by break ranges
    logic pass_event;
    always_comb
    begin
        if (PASS_USE_EVENT)
            pass_event = EVENT_IN;
        else
            pass_event = CYC.valid && in_range(PASS_RANGE, CYC.addr);
    end

    // ------------------------------------------------------------
    // Stopwatch
    // ------------------------------------------------------------
    logic [tpc_pkg::TS_W-1:0] sw_q;
    always_ff @(posedge CLK)
    begin
        if (!RST_N || SW_CLEAR)
            sw_q <= tpc_pkg::TS_RST;
        else
            sw_q <= sw_q + 1'b1;
    end

    // ------------------------------------------------------------
    // Pass counter
    // ------------------------------------------------------------
    tpc_pkg::tpc_pc_state_t pc_q;
    logic [tpc_pkg::PASS_W-1:0] pass_q;
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pc_q <= tpc_pkg::PC_IDLE;
            pass_q <= tpc_pkg::PASS_RST;
        end
        else if (PASS_LOAD && CORE_HALTED)
        begin
            // Loads while the core runs are ignored
            pass_q <= PASS_LOAD_VAL;
            pc_q <= (PASS_LOAD_VAL == '0) ? tpc_pkg::PC_DONE : tpc_pkg::PC_COUNT;
        end
        else
        begin
            case (pc_q)
                tpc_pkg::PC_IDLE:
                    pc_q <= tpc_pkg::PC_IDLE;
                tpc_pkg::PC_COUNT:
                    if (PASS_EN && pass_event)
                    begin
                        pass_q <= pass_q - 1'b1;
                        if (pass_q == 16'h0001)
                            pc_q <= tpc_pkg::PC_DONE;
                    end
                tpc_pkg::PC_DONE:
                    pc_q <= tpc_pkg::PC_DONE;
                default:
                    pc_q <= tpc_pkg::PC_IDLE;
            endcase
        end
    end

    logic reached;
    assign reached = (pc_q == tpc_pkg::PC_COUNT) && PASS_EN && pass_event
        && (pass_q == 16'h0001);

    // ------------------------------------------------------------
    // Trace capture
    // ------------------------------------------------------------
    logic frozen_q;
    logic halt_req_d1_q;
    logic wr_en;
    logic gate_open;
    logic mem_full;
    tpc_pkg::tpc_rec_t wr_rec;

    // Halt request is edge-detected so each press toggles freeze state
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            frozen_q <= 1'b0;
            halt_req_d1_q <= 1'b0;
        end
        else
        begin
            halt_req_d1_q <= TRACE_HALT_REQ;
            if (TRACE_HALT_REQ && !halt_req_d1_q)
                frozen_q <= !frozen_q;
        end
    end

    // Gate stays shut in trace mode until the count has run out
    assign gate_open = !PASS_TO_TRACE || (pc_q == tpc_pkg::PC_DONE);
    assign wr_en = TRACE_EN && CYC.valid && !frozen_q && gate_open;
    always_comb
    begin
        wr_rec.addr = CYC.addr;
        wr_rec.data = CYC.data;
        wr_rec.stamp = sw_q;
        wr_rec.changed = CYC.changed;
    end

    tpc_trace_mem #(
        .DEPTH(DEPTH)
    ) u_mem (
        .clk(CLK),
        .rst_n(RST_N),
        .wr_en(wr_en),
        .wr_rec(wr_rec),
        .rd_idx(RD_IDX),
        .rd_rec(RD_REC),
        .wr_ptr(WR_PTR),
        .full(mem_full)
    );

    logic fill_now;
    assign fill_now = wr_en && (WR_PTR == AW'(DEPTH - 1)) && !mem_full;

    // ------------------------------------------------------------
    // Registered outputs and halt
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            BUF_FULL <= 1'b0;
            TRACE_FROZEN <= 1'b0;
            PASS_COUNT <= tpc_pkg::PASS_RST;
            PASS_ZERO <= 1'b0;
            STOPWATCH <= tpc_pkg::TS_RST;
            HALT_REQ <= 1'b0;
        end
        else
        begin
            BUF_FULL <= mem_full || fill_now;
            TRACE_FROZEN <= frozen_q;
            PASS_COUNT <= pass_q;
            PASS_ZERO <= (pc_q == tpc_pkg::PC_DONE);
            STOPWATCH <= sw_q;
            // Registered OR of the causes, not latched; the core holds its own halted state
            HALT_REQ <= (|brk_hit) || EXT_BREAK
                || (reached && !PASS_TO_TRACE)
                || (fill_now && BREAK_ON_FULL);
        end
    end
endmodule

// [dv/tpc_chk.sv]
// Concurrent checks on the trace and pass counter ports
`timescale 1ns/1ps
module tpc_chk #(
    parameter int NUM_BRK = 4,
    parameter int DEPTH = 8192
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire tpc_pkg::tpc_cyc_t CYC,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic FETCH_VALID,
    input wire logic EXT_BREAK,
    input wire tpc_pkg::tpc_range_t [NUM_BRK-1:0] BRK_RANGE,
    input wire logic [NUM_BRK-1:0] BRK_EN,
    input wire logic PASS_LOAD,
    input wire logic PASS_TO_TRACE,
    input wire logic TRACE_EN,
    input wire logic TRACE_HALT_REQ,
    input wire logic [$clog2(DEPTH)-1:0] WR_PTR,
    input wire logic BUF_FULL,
    input wire logic TRACE_FROZEN,
    input wire logic [15:0] PASS_COUNT,
    input wire logic PASS_ZERO,
    input wire logic HALT_REQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // Count view lags a cycle, so a load is masked for two cycles
    a_count_step: assert property (PASS_COUNT != $past(PASS_COUNT)
        && !$past(PASS_LOAD) && !$past(PASS_LOAD, 2) |-> PASS_COUNT == $past(PASS_COUNT) - 1'b1)
        else $error("count moved by other than one");
    // Zero flag trails the halt pulse by one cycle
    a_pass_zero: assert property ($rose(PASS_ZERO) && !PASS_TO_TRACE
        && !$past(PASS_LOAD) && !$past(PASS_LOAD, 2) |-> $past(HALT_REQ))
        else $error("zero without halt");
    a_brk_hit: assert property (FETCH_VALID && BRK_EN[0]
        && FETCH_ADDR >= BRK_RANGE[0].start_addr && FETCH_ADDR <= BRK_RANGE[0].end_addr
        |=> HALT_REQ) else $error("break hit without halt");
    a_ext_break: assert property (EXT_BREAK |=> HALT_REQ) else $error("external break lost");
    // Frozen view lags the request by two cycles, hence the look back
    a_wr_advance: assert property (CYC.valid && TRACE_EN && !TRACE_FROZEN
        && !TRACE_HALT_REQ && !$past(TRACE_HALT_REQ) && !PASS_TO_TRACE && !BUF_FULL
        |=> WR_PTR == $past(WR_PTR) + 1'b1) else $error("valid cycle not written");
    a_wr_frozen: assert property (TRACE_FROZEN && !TRACE_HALT_REQ
        && !$past(TRACE_HALT_REQ) |=> $stable(WR_PTR)) else $error("write while frozen");
    // Margin of two keeps a same-edge reach of zero out of the antecedent
    a_trace_gate: assert property (PASS_TO_TRACE && PASS_COUNT > 16'h0002
        && !PASS_LOAD && !$past(PASS_LOAD) |=> $stable(WR_PTR)) else $error("write before zero");
    a_full_sticky: assert property (BUF_FULL |=> BUF_FULL) else $error("full flag dropped");
    c_frozen: cover property ($rose(TRACE_FROZEN));
    c_full: cover property ($rose(BUF_FULL));
    c_zero_halt: cover property ($rose(PASS_ZERO) && $past(HALT_REQ));
endmodule
bind tpc_trace_pass tpc_chk #(.NUM_BRK(NUM_BRK), .DEPTH(DEPTH)) u_chk (.CLK, .RST_N, .CYC,
    .FETCH_ADDR, .FETCH_VALID, .EXT_BREAK, .BRK_RANGE, .BRK_EN, .PASS_LOAD, .PASS_TO_TRACE,
    .TRACE_EN, .TRACE_HALT_REQ, .WR_PTR, .BUF_FULL, .TRACE_FROZEN, .PASS_COUNT, .PASS_ZERO,
    .HALT_REQ);

// [dv/tpc_core_model.sv]
// Behavioural core that runs straight-line code and stops on halt requests
`timescale 1ns/1ps
module tpc_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] pc_init,
    input wire logic halt_req,
    output tpc_pkg::tpc_cyc_t cyc,
    output logic [15:0] fetch_addr,
    output logic fetch_valid,
    output logic halted
);
    logic dec_valid_q;
    logic [15:0] dec_addr_q;

    // A decode stage sits between fetch and execute, so a halt raised on the
    // fetch address drops that instruction before it executes
    always_ff @(posedge clk)
    begin
        if (!rst_n || go || halt_req || halted)
        begin
            cyc <= '0;
            dec_valid_q <= 1'b0;
            dec_addr_q <= 16'h0000;
            fetch_addr <= pc_init;
            fetch_valid <= go;
            halted <= !go;
        end
        else
        begin
            dec_valid_q <= fetch_valid;
            dec_addr_q <= fetch_addr;
            cyc <= {dec_valid_q, dec_addr_q, ~dec_addr_q, dec_addr_q ^ 16'h00FF};
            fetch_addr <= fetch_addr + 16'h0001;
        end
    end
endmodule

// [dv/tpc_trace_pass_tb.sv]
// Self-checking bench for the trace and pass counter block
`timescale 1ns/1ps
module tpc_trace_pass_tb;
    logic CLK = 0, RST_N = 0, FETCH_VALID, CORE_HALTED, EVENT_IN = 0, EXT_BREAK = 0, go = 0;
    logic PASS_EN = 0, PASS_USE_EVENT = 0, PASS_TO_TRACE = 0, PASS_LOAD = 0, TRACE_EN = 0;
    logic BREAK_ON_FULL = 0, TRACE_HALT_REQ = 0, SW_CLEAR = 0, TRACE_FROZEN, PASS_ZERO;
    logic BUF_FULL, HALT_REQ;
    logic [3:0] BRK_EN = '0;
    logic [15:0] FETCH_ADDR, PASS_LOAD_VAL = '0, PASS_COUNT, pc = '0;
    logic [12:0] RD_IDX = '0, WR_PTR, p0, nv = '0, n0;
    logic [31:0] STOPWATCH;
    tpc_pkg::tpc_cyc_t CYC;
    tpc_pkg::tpc_range_t [3:0] BRK_RANGE = '0;
    tpc_pkg::tpc_range_t PASS_RANGE = '0;
    tpc_pkg::tpc_rec_t RD_REC;
    int fail_count = 0, cmp_count = 0;
    always #12.5 CLK = ~CLK;
    always @(posedge CLK)
        if (CYC.valid) nv <= nv + 1'b1;
    tpc_core_model CORE (.clk(CLK), .rst_n(RST_N), .go, .pc_init(pc), .halt_req(HALT_REQ),
        .cyc(CYC), .fetch_addr(FETCH_ADDR), .fetch_valid(FETCH_VALID), .halted(CORE_HALTED));
    tpc_trace_pass DUT (.CLK, .RST_N, .CYC, .FETCH_ADDR, .FETCH_VALID, .CORE_HALTED, .EVENT_IN,
        .EXT_BREAK, .BRK_RANGE, .BRK_EN, .PASS_RANGE, .PASS_EN, .PASS_USE_EVENT, .PASS_TO_TRACE,
        .PASS_LOAD, .PASS_LOAD_VAL, .TRACE_EN, .BREAK_ON_FULL, .TRACE_HALT_REQ, .SW_CLEAR, .RD_IDX,
        .RD_REC, .WR_PTR, .BUF_FULL, .TRACE_FROZEN, .PASS_COUNT, .PASS_ZERO, .STOPWATCH, .HALT_REQ);
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Trailing idle cycle keeps two pulses from landing in one time step
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
        tick(1);
    endtask
    task automatic load(input logic [15:0] v);
        PASS_LOAD_VAL = v;
        pulse(PASS_LOAD);
        tick(1);
    endtask
    task automatic start(input logic [15:0] a);
        pc = a;
        n0 = nv;
        p0 = WR_PTR;
        pulse(go);
    endtask
    task automatic wait_halt(input int lim);
        int i;
        for (i = 0; i < lim && CORE_HALTED !== 1'b1; i++)
            tick(1);
        if (i == lim)
        begin
            chk(1'b0, "core never halted");
            finish_test();
        end
        tick(2);
    endtask
    task automatic sc_break();
        TRACE_EN = 1;
        PASS_EN = 1;
        PASS_RANGE = {16'h0500, 16'h0500};
        BRK_RANGE[0] = {16'h0104, 16'h0104};
        BRK_EN = 4'h1;
        start(16'h0100);
        load(16'h0005);
        wait_halt(50);
        chk(PASS_COUNT === 16'h0000, "load taken while running");
        chk(WR_PTR === p0 + (nv - n0), "write count");
        RD_IDX = p0;
        tick(2);
        chk(RD_REC.addr === 16'h0100 && RD_REC.data === 16'hFEFF
            && RD_REC.changed === 16'h01FF, "record fields");
        RD_IDX = WR_PTR - 1'b1;
        tick(2);
        chk(RD_REC.addr === 16'h0103, "break address executed");
    endtask
    task automatic sc_pass_break();
        BRK_EN = '0;
        PASS_RANGE = {16'h0200, 16'h0202};
        load(16'h0003);
        chk(PASS_COUNT === 16'h0003, "load value");
        start(16'h0200);
        wait_halt(50);
        chk(PASS_ZERO === 1'b1 && PASS_COUNT === 16'h0000, "pass zero");
        chk(nv - n0 < 13'h8, "late halt");
    endtask
    task automatic sc_pass_trace();
        PASS_TO_TRACE = 1;
        PASS_RANGE = {16'h0302, 16'h0304};
        BRK_RANGE[0] = {16'h0308, 16'h0308};
        BRK_EN = 4'h1;
        load(16'h0003);
        start(16'h0300);
        wait_halt(50);
        RD_IDX = p0;
        tick(2);
        chk(RD_REC.addr inside {16'h0304, 16'h0305}, "gated start");
        chk(WR_PTR - p0 > 13'h2, "capture after zero");
        PASS_TO_TRACE = 0;
    endtask
    task automatic sc_event();
        PASS_USE_EVENT = 1;
        load(16'h0004);
        repeat (3) pulse(EVENT_IN);
        tick(1);
        chk(PASS_COUNT === 16'h0001, "event count");
        pulse(EVENT_IN);
        tick(1);
        chk(PASS_ZERO === 1'b1, "event zero");
        PASS_USE_EVENT = 0;
    endtask
    task automatic sc_freeze();
        PASS_EN = 0;
        BRK_EN = '0;
        start(16'h0400);
        tick(3);
        pulse(TRACE_HALT_REQ);
        p0 = WR_PTR;
        tick(5);
        chk(TRACE_FROZEN === 1'b1 && WR_PTR === p0 && CORE_HALTED === 1'b0, "freeze");
        pulse(TRACE_HALT_REQ);
        tick(2);
        chk(WR_PTR !== p0, "fresh capture");
        pulse(SW_CLEAR);
        RD_IDX = WR_PTR - 1'b1;
        chk(STOPWATCH === 32'h0000_0000, "stopwatch clear");
        tick(2);
        chk(RD_REC.stamp === 32'h0000_0000, "stamp base clear");
        pulse(EXT_BREAK);
        wait_halt(10);
    endtask
    initial
    begin
        tick(16);
        RST_N = 1;
        sc_break();
        sc_pass_break();
        sc_pass_trace();
        sc_event();
        sc_freeze();
        BREAK_ON_FULL = 1;
        start(16'h1000);
        wait_halt(9000);
        chk(BUF_FULL === 1'b1, "full halt");
        finish_test();
    end
endmodule
